/* hostsel_pkg.sv */
// Constants, modes and field positions for the host interface selector
// Summary of operation
// - 0000/0001: type A, 8 or 9 bits
// - 0010/0011: type A, 16 or 18 bits
// - 0100/0101: type B, 8 or 9 bits
// - 0110/0111: type B, 16 or 18 bits
// - 1010: type B, full 24 bits
// - 1000: link command mode on lanes
// - 1001: three-wire serial, 9-bit frames
// - 1100: link video mode, same lanes
// - 1101-1111: pixel bus plus serial configuration
// - Type A: enable high allows access
// - Type B: read strobe low drives data
// - Write strobe, or serial data/command pin
// - Data/command select, or serial clock
// - Serial in sampled, serial out returns
// - Latched regulator strap, high disables
// - Clock lane plus data lanes 0, 1
// - Active-low hardware reset
package hostsel_pkg;
  // Interface modes, codes equal the strap value
  typedef enum logic [3:0] {
    M_A8 = 4'h0, M_A9 = 4'h1, M_A16 = 4'h2, M_A18 = 4'h3,
    M_B8 = 4'h4, M_B9 = 4'h5, M_B16 = 4'h6, M_B18 = 4'h7,
    M_LCMD = 4'h8, M_SER = 4'h9, M_B24 = 4'hA, M_RSVD = 4'hB,
    M_LVID = 4'hC, M_C1 = 4'hD, M_C2 = 4'hE, M_C3 = 4'hF
  } mode_t;
  localparam int BUS_W = 24;
  localparam int WORD_W = 25;
  localparam int FIFO_DEPTH = 16;
  // Synchronised vector field positions
  localparam int F_STRAP = 0;
  localparam int F_REGDIS = 4;
  localparam int F_CS = 5;
  localparam int F_RDE = 6;
  localparam int F_WR = 7;
  localparam int F_DCS = 8;
  localparam int F_SDI = 9;
  localparam int F_VS = 10;
  localparam int F_HS = 11;
  localparam int F_DE = 12;
  localparam int F_PCLK = 13;
  localparam int F_LANE = 14;
  localparam int F_BUS = 20;
  localparam int SYNC_W = 44;
  // Cycles after release before straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Serial frame lengths
  localparam logic [3:0] SER_BITS_3W = 4'h9;
  localparam logic [3:0] SER_BITS_4W = 4'h8;
  // Reset values
  localparam logic [3:0] MODE_RST = 4'hB;
endpackage

/* hostsel_top.sv */
// Host interface selector: strap decode, pin roles, word capture, FIFO
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Word FIFO, flip-flop storage, registered flags
module word_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr; // Write index
  logic [AW-1:0] rd_ptr; // Read index
  logic [AW:0] count; // Fill level
  logic [AW:0] next_count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];
  // Level after this edge
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end
  // Flags are flops so both sides see clean levels
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count <= next_count;
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      in_ready_o <= next_count != (AW + 1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end
  // Storage has no reset, saves area
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Top: decodes straps and gives each shared pin its role
module hostsel_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Straps
  input wire logic IFACE_STRAP_BIT0_I,
  input wire logic IFACE_STRAP_BIT1_I,
  input wire logic IFACE_STRAP_BIT2_I,
  input wire logic IFACE_STRAP_BIT3_I,
  input wire logic LINK_REGULATOR_DISABLE_I,
  // Shared control pins
  input wire logic CHIP_SELECT_N_I,
  input wire logic READ_STROBE_OR_ENABLE_I,
  input wire logic WRITE_STROBE_OR_SERIAL_DC_I,
  input wire logic PARALLEL_DC_OR_SERIAL_CLOCK_I,
  // Serial data
  input wire logic SERIAL_IN_I,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE_O,
  // Parallel data bus
  input wire logic [23:0] PARALLEL_DATA_BUS_I,
  output logic [23:0] PARALLEL_DATA_BUS_O,
  output logic PARALLEL_DATA_BUS_OE_O,
  // Pixel video pins
  input wire logic FRAME_SYNC_I,
  input wire logic LINE_SYNC_I,
  input wire logic PIXEL_VALID_I,
  input wire logic PIXEL_CLOCK_I,
  // Differential link lanes
  input wire logic LINK_CLK_P_I,
  input wire logic LINK_CLK_N_I,
  input wire logic LINK_LANE0_P_I,
  input wire logic LINK_LANE0_N_I,
  input wire logic LINK_LANE1_P_I,
  input wire logic LINK_LANE1_N_I,
  // User side
  input wire logic [23:0] READ_DATA_I,
  output logic [23:0] WORD_DATA_O,
  output logic WORD_DC_O,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic ACCEPT_READY_O,
  output logic [3:0] MODE_O,
  output logic FRAME_SYNC_O,
  output logic LINE_SYNC_O,
  output logic LINK_RX_EN_O,
  output logic LINK_REG_EN_O,
  output logic [2:0] LINK_LANES_O
);
  //////////////////////////////////////////////////////////////////////
  // Helper functions
  // Data lines in use for a mode
  function automatic logic [23:0] width_mask(input logic [3:0] m);
    case (m)
      4'h0, 4'h4: return 24'h0000FF;
      4'h1, 4'h5: return 24'h0001FF;
      4'h2, 4'h6: return 24'h00FFFF;
      4'h3, 4'h7: return 24'h03FFFF;
      4'hA, 4'hD, 4'hE, 4'hF: return 24'hFFFFFF;
      default: return 24'h000000;
    endcase
  endfunction
  // Parallel type A group
  function automatic logic is_a(input logic [3:0] m);
    return m[3:2] == 2'h0;
  endfunction
  // Parallel type B group
  function automatic logic is_b(input logic [3:0] m);
    return (m[3:2] == 2'h1) || (m == 4'hA);
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for every pin input
  wire [hostsel_pkg::SYNC_W-1:0] raw = {
    PARALLEL_DATA_BUS_I,
    LINK_LANE1_N_I, LINK_LANE1_P_I, LINK_LANE0_N_I,
    LINK_LANE0_P_I, LINK_CLK_N_I, LINK_CLK_P_I,
    PIXEL_CLOCK_I, PIXEL_VALID_I, LINE_SYNC_I, FRAME_SYNC_I,
    SERIAL_IN_I, PARALLEL_DC_OR_SERIAL_CLOCK_I,
    WRITE_STROBE_OR_SERIAL_DC_I, READ_STROBE_OR_ENABLE_I,
    CHIP_SELECT_N_I, LINK_REGULATOR_DISABLE_I,
    IFACE_STRAP_BIT3_I, IFACE_STRAP_BIT2_I,
    IFACE_STRAP_BIT1_I, IFACE_STRAP_BIT0_I};
  logic [hostsel_pkg::SYNC_W-1:0] s1; // First stage, read only by s2
  logic [hostsel_pkg::SYNC_W-1:0] s2; // Safe sampled levels
  logic [hostsel_pkg::SYNC_W-1:0] s3; // Previous, for edges
  // Shift pins through; all stages, straps included, reset to zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Named sampled pins and edges
  wire cs_n = s2[hostsel_pkg::F_CS];
  wire rde = s2[hostsel_pkg::F_RDE];
  wire wr = s2[hostsel_pkg::F_WR];
  wire dcs = s2[hostsel_pkg::F_DCS];
  wire serial_in = s2[hostsel_pkg::F_SDI];
  wire de = s2[hostsel_pkg::F_DE];
  wire [23:0] bus = s2[hostsel_pkg::F_BUS +: 24];
  wire rde_fall = s3[hostsel_pkg::F_RDE] & ~rde;
  wire wr_rise = ~s3[hostsel_pkg::F_WR] & wr;
  wire sck_rise = ~s3[hostsel_pkg::F_DCS] & dcs;
  wire sck_fall = s3[hostsel_pkg::F_DCS] & ~dcs;
  wire cs_fall = s3[hostsel_pkg::F_CS] & ~cs_n;
  wire pclk_rise = ~s3[hostsel_pkg::F_PCLK] & s2[hostsel_pkg::F_PCLK];
  //////////////////////////////////////////////////////////////////////
  // Strap latch, once per reset
  logic [1:0] settle; // Counts sync pipeline fill
  logic latched; // Straps captured
  hostsel_pkg::mode_t mode; // Held selection
  logic reg_dis; // Held regulator strap, low by default
  // Straps are static, so one late sample is enough
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      settle <= 2'h0;
      latched <= 1'b0;
      mode <= hostsel_pkg::M_RSVD;
      reg_dis <= 1'b0;
    end else if (!latched) begin
      settle <= settle + 2'h1;
      if (settle == hostsel_pkg::STRAP_SETTLE) begin
        latched <= 1'b1;
        mode <= hostsel_pkg::mode_t'(s2[3:0]);
        reg_dis <= s2[hostsel_pkg::F_REGDIS];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Mode decode
  wire [23:0] mask = width_mask(mode);
  wire m_a = latched & is_a(mode);
  wire m_b = latched & is_b(mode);
  wire m_3w = latched & (mode == hostsel_pkg::M_SER);
  wire m_c = latched & (mode[3:2] == 2'h3) & (mode[1:0] != 2'h0);
  wire m_ser = m_3w | m_c; // Serial port live
  wire m_lnk = latched & ((mode == hostsel_pkg::M_LCMD) |
    (mode == hostsel_pkg::M_LVID));
  // Type A: enable high, write pin low means write
  wire a_wr = m_a & ~cs_n & rde_fall & ~wr;
  wire a_rd = m_a & ~cs_n & rde & wr;
  // Type B: write strobe rising captures, read strobe low reads
  wire b_wr = m_b & ~cs_n & wr_rise;
  wire b_rd = m_b & ~cs_n & ~rde;
  wire par_wr = a_wr | b_wr;
  //////////////////////////////////////////////////////////////////////
  // Serial shifter
  logic [8:0] sh; // Incoming bits
  logic [3:0] nbits; // Bits in frame
  logic [7:0] so; // Outgoing bits
  wire [3:0] flen = m_3w ? hostsel_pkg::SER_BITS_3W :
    hostsel_pkg::SER_BITS_4W;
  wire [8:0] next_sh = {sh[7:0], serial_in};
  wire ser_done = m_ser & ~cs_n & sck_rise & (nbits + 4'h1 == flen);
  // First bit is data/command in three-wire frames
  wire ser_dc = m_3w ? next_sh[8] : wr;
  // Sample on clock rise, shift out on clock fall
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sh <= 9'h000;
      nbits <= 4'h0;
      so <= 8'h00;
    end else if (!m_ser || cs_n || cs_fall) begin
      nbits <= 4'h0;
      so <= READ_DATA_I[7:0];
    end else if (sck_rise) begin
      sh <= next_sh;
      nbits <= ser_done ? 4'h0 : nbits + 4'h1;
    end else if (sck_fall) begin
      so <= {so[6:0], 1'b0};
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Capture source select; pixels win over serial words
  wire pix = m_c & pclk_rise & de;
  wire cap = pix | par_wr | ser_done;
  wire [23:0] cap_data = pix ? (bus & mask) :
    par_wr ? (bus & mask) : {16'h0000, next_sh[7:0]};
  wire cap_dc = pix ? 1'b1 : par_wr ? dcs : ser_dc;
  wire f_ready;
  wire f_valid;
  wire [hostsel_pkg::WORD_W-1:0] f_data;
  wire take = f_valid & (~WORD_VALID_O | WORD_READY_I);
  // Words dropped when full; host sees ACCEPT_READY_O low
  word_fifo #(
    .WIDTH(hostsel_pkg::WORD_W),
    .DEPTH(hostsel_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(cap),
    .in_ready_o(f_ready),
    .in_data_i({cap_dc, cap_data}),
    .out_valid_o(f_valid),
    .out_ready_i(take),
    .out_data_o(f_data)
  );
  assign ACCEPT_READY_O = f_ready;
  //////////////////////////////////////////////////////////////////////
  // Output register stage so user outputs come from flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WORD_VALID_O <= 1'b0;
      WORD_DATA_O <= 24'h000000;
      WORD_DC_O <= 1'b0;
    end else if (take) begin
      WORD_VALID_O <= 1'b1;
      WORD_DATA_O <= f_data[23:0];
      WORD_DC_O <= f_data[24];
    end else if (WORD_READY_I) begin
      WORD_VALID_O <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Pin drivers; reserved code leaves all of them idle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PARALLEL_DATA_BUS_O <= 24'h000000;
      PARALLEL_DATA_BUS_OE_O <= 1'b0;
      SERIAL_OUT_O <= 1'b0;
      SERIAL_OUT_OE_O <= 1'b0;
      MODE_O <= hostsel_pkg::MODE_RST;
      FRAME_SYNC_O <= 1'b0;
      LINE_SYNC_O <= 1'b0;
      LINK_RX_EN_O <= 1'b0;
      LINK_REG_EN_O <= 1'b0;
      LINK_LANES_O <= 3'h0;
    end else begin
      PARALLEL_DATA_BUS_OE_O <= a_rd | b_rd;
      PARALLEL_DATA_BUS_O <= READ_DATA_I & mask;
      SERIAL_OUT_OE_O <= m_ser & ~cs_n;
      SERIAL_OUT_O <= m_ser & ~cs_n & so[7];
      MODE_O <= mode;
      FRAME_SYNC_O <= m_c & s2[hostsel_pkg::F_VS];
      LINE_SYNC_O <= m_c & s2[hostsel_pkg::F_HS];
      LINK_RX_EN_O <= m_lnk;
      LINK_REG_EN_O <= m_lnk & ~reg_dis;
      LINK_LANES_O <= m_lnk ? {
        s2[18] & ~s2[19], s2[16] & ~s2[17],
        s2[14] & ~s2[15]} : 3'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_mode_held;
    latched |=> $stable(mode) && latched;
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("selection changed after latch");
  property p_rsvd_idle;
    (mode == hostsel_pkg::M_RSVD) |=> !PARALLEL_DATA_BUS_OE_O &&
      !SERIAL_OUT_OE_O && !LINK_RX_EN_O && !FRAME_SYNC_O;
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle)
    else $error("reserved mode drives an output");
  property p_b_read;
    m_b && !cs_n && !rde |=> PARALLEL_DATA_BUS_OE_O;
  endproperty
  a_b_read: assert property (p_b_read) else $error("type B read not driven");
  property p_a_gate;
    m_a && !rde |=> !PARALLEL_DATA_BUS_OE_O;
  endproperty
  a_a_gate: assert property (p_a_gate)
    else $error("type A drove bus while disabled");
  property p_reg;
    latched && (mode == hostsel_pkg::M_LCMD) |=> LINK_REG_EN_O == !reg_dis;
  endproperty
  a_reg: assert property (p_reg) else $error("regulator enable wrong");
  property p_cs_gate;
    cs_n && !pix |-> !cap;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("capture with chip select high");
  property p_width;
    cap && f_ready |-> (cap_data & ~mask) == 24'h000000 || ser_done;
  endproperty
  a_width: assert property (p_width)
    else $error("unused data line captured");
  property p_ser_oe;
    m_ser && !cs_n ##1 m_ser && !cs_n |-> SERIAL_OUT_OE_O;
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial out not enabled");
  property p_pix;
    pix |-> m_c && de;
  endproperty
  a_pix: assert property (p_pix) else $error("pixel taken outside video mode");
  c_a_write: cover property (a_wr && f_ready);
  c_b_read: cover property (b_rd ##1 PARALLEL_DATA_BUS_OE_O);
  c_ser_word: cover property (ser_done);
  c_full: cover property (!f_ready);
endmodule

`default_nettype wire

/* host_model.sv */
// Host-side model driving the shared parallel control pins and data bus
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module host_model (
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic cs_n_o,
  output logic rde_o,
  output logic wr_o,
  output logic dc_o,
  output logic [23:0] bus_o,
  // Serial data pins
  output logic sdi_o,
  input wire logic sdo_i
);
  // Idle state: deselected, both strobes high
  initial begin
    cs_n_o = 1'b1;
    rde_o = 1'b1;
    wr_o = 1'b1;
    dc_o = 1'b0;
    bus_o = 24'h000000;
    sdi_o = 1'b0;
  end

  // One write; 4 clocks between pin edges keeps the synchroniser spacing
  task automatic write(input logic type_a, input logic [23:0] d, input logic dc);
    @(posedge clk_i);
    cs_n_o <= 1'b0; // Select held low for the whole access
    dc_o <= dc;
    bus_o <= d;
    rde_o <= 1'b1; // Type A enable high, type B read idle
    wr_o <= !type_a;
    repeat (4) @(posedge clk_i);
    if (type_a) rde_o <= 1'b0; // Enable falling captures
    else wr_o <= 1'b0; // Write strobe low
    repeat (4) @(posedge clk_i);
    if (type_a) rde_o <= 1'b1;
    else wr_o <= 1'b1; // Rising strobe captures
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    wr_o <= 1'b1;
    bus_o <= ~d; // Released bus must not keep the old value
    repeat (4) @(posedge clk_i);
  endtask

  // Read access, held until end_read
  task automatic start_read(input logic type_a);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rde_o <= type_a; // Type A enable high, type B strobe low
    wr_o <= 1'b1; // Read direction for type A
  endtask

  // One serial frame, MSB first; the clock rests low outside frames
  task automatic ser_frame(input logic [8:0] bits, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    dc_o <= 1'b0; // Park the clock before selecting
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= bits[i];
      repeat (4) @(posedge clk_i);
      dc_o <= 1'b1; // Device samples on the rise
      if (i >= n - 8) rx = {rx[6:0], sdo_i}; // Reply bit taken at the same edge
      repeat (4) @(posedge clk_i);
      dc_o <= 1'b0; // Device shifts its reply on the fall
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    sdi_o <= ~bits[0]; // Released line must not keep the old value
    repeat (4) @(posedge clk_i);
  endtask

  task automatic end_read;
    @(posedge clk_i);
    rde_o <= 1'b1;
    cs_n_o <= 1'b1;
  endtask

  // Pixel data presented on the bus
  task automatic set_bus(input logic [23:0] d);
    @(posedge clk_i);
    bus_o <= d;
  endtask
endmodule
`default_nettype wire

/* display_host_interface_select_test.sv */
// Self-checking bench for the host interface selector
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module display_host_interface_select_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] strap = 4'h0;
  logic regdis = 1'b0;
  logic cs_n, rde, wr, dc, serial_in;
  logic [23:0] bus;
  logic fsync = 1'b0;
  logic pvalid = 1'b0;
  logic pclk = 1'b0;
  logic pix_run = 1'b0;
  logic [2:0] lane_p = 3'h0;
  logic [23:0] rdata = 24'h000000;
  logic word_ready = 1'b1;
  logic sout, sout_oe, bus_oe, word_dc, word_valid, acc_ready, fs_o, ls_o, rx_en, reg_en;
  logic [23:0] bus_out, word_data;
  logic [3:0] mode;
  logic [2:0] lanes;
  int n_mismatch = 0;
  int tests_run = 0;

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  // 200 ns pixel clock, offset so it never shares an edge with clk
  initial begin
    #3;
    forever begin
      #100;
      pclk = pix_run ? ~pclk : 1'b0;
    end
  end

  host_model u_host (.clk_i(clk), .cs_n_o(cs_n), .rde_o(rde), .wr_o(wr), .dc_o(dc),
    .bus_o(bus), .sdi_o(serial_in), .sdo_i(sout));

  hostsel_top u_dut (.CLK_I(clk), .RST_N_I(rst_n),
    .IFACE_STRAP_BIT0_I(strap[0]), .IFACE_STRAP_BIT1_I(strap[1]),
    .IFACE_STRAP_BIT2_I(strap[2]), .IFACE_STRAP_BIT3_I(strap[3]),
    .LINK_REGULATOR_DISABLE_I(regdis), .CHIP_SELECT_N_I(cs_n),
    .READ_STROBE_OR_ENABLE_I(rde), .WRITE_STROBE_OR_SERIAL_DC_I(wr),
    .PARALLEL_DC_OR_SERIAL_CLOCK_I(dc), .SERIAL_IN_I(serial_in), .SERIAL_OUT_O(sout),
    .SERIAL_OUT_OE_O(sout_oe), .PARALLEL_DATA_BUS_I(bus), .PARALLEL_DATA_BUS_O(bus_out),
    .PARALLEL_DATA_BUS_OE_O(bus_oe), .FRAME_SYNC_I(fsync), .LINE_SYNC_I(fsync),
    .PIXEL_VALID_I(pvalid), .PIXEL_CLOCK_I(pclk), .LINK_CLK_P_I(lane_p[0]),
    .LINK_CLK_N_I(~lane_p[0]), .LINK_LANE0_P_I(lane_p[1]), .LINK_LANE0_N_I(~lane_p[1]),
    .LINK_LANE1_P_I(lane_p[2]), .LINK_LANE1_N_I(~lane_p[2]), .READ_DATA_I(rdata),
    .WORD_DATA_O(word_data), .WORD_DC_O(word_dc), .WORD_VALID_O(word_valid),
    .WORD_READY_I(word_ready), .ACCEPT_READY_O(acc_ready), .MODE_O(mode),
    .FRAME_SYNC_O(fs_o), .LINE_SYNC_O(ls_o), .LINK_RX_EN_O(rx_en), .LINK_REG_EN_O(reg_en),
    .LINK_LANES_O(lanes));

  // Data lanes kept per mode width
  function automatic logic [23:0] mask_for(input logic [3:0] m);
    case (m)
      4'h0, 4'h4: mask_for = 24'h0000FF;
      4'h1, 4'h5: mask_for = 24'h0001FF;
      4'h2, 4'h6: mask_for = 24'h00FFFF;
      4'h3, 4'h7: mask_for = 24'h03FFFF;
      default: mask_for = 24'hFFFFFF;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Straps must be steady across reset release
  task automatic apply_reset(input logic [3:0] m, input logic rd);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= m; // Tied before release, left alone afterwards
    regdis <= rd;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // Bounded wait for one word; returns 0 when none came
  task automatic get_word(output logic got);
    got = 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (word_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  // Watchdog well above the expected run length
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [3:0] m;
    logic [23:0] d;
    logic got, dcb, is_link;
    logic [8:0] sbits;
    logic [7:0] rx;
    int cnt;
    void'($urandom(52829));
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      is_link = (m == 4'h8) || (m == 4'hC);
      apply_reset(m, 1'($urandom));
      lane_p <= 3'($urandom);
      fsync <= 1'b1;
      repeat (6) @(posedge clk);
      check("mode", 32'(mode), 32'(m));
      check("link_rx", 32'(rx_en), 32'(is_link));
      check("reg_en", 32'(reg_en), 32'(is_link && !regdis));
      check("lanes", 32'(lanes), is_link ? 32'(lane_p) : 32'h0);
      check("fsync", 32'(fs_o), 32'(m >= 4'hD));
      check("lsync", 32'(ls_o), 32'(m >= 4'hD));
      fsync <= 1'b0;
      d = 24'($urandom);
      dcb = 1'($urandom);
      word_ready <= 1'b0; // A word stands only while unaccepted, so hold it for the look
      u_host.write(m < 4'h4, d, dcb);
      if (m <= 4'h7 || m == 4'hA) begin
        get_word(got);
        check("got", 32'(got), 32'h1);
        check("data", 32'(word_data), 32'(d & mask_for(m)));
        check("dc", 32'(word_dc), 32'(dcb));
      end
      if (m <= 4'h7) begin
        rdata <= 24'($urandom);
        u_host.start_read(m < 4'h4);
        repeat (6) @(posedge clk);
        check("rd_oe", 32'(bus_oe), 32'h1);
        check("rd_data", 32'(bus_out), 32'(rdata & mask_for(m)));
        u_host.end_read();
        repeat (6) @(posedge clk);
        check("rd_off", 32'(bus_oe), 32'h0);
      end
      if (m == 4'h9 || m == 4'hD) begin
        sbits = 9'($urandom);
        rdata <= 24'($urandom);
        u_host.ser_frame(sbits, (m == 4'h9) ? 9 : 8, rx);
        get_word(got);
        check("ser_got", 32'(got), 32'h1);
        check("ser_data", 32'(word_data), 32'(sbits[7:0]));
        check("ser_dc", 32'(word_dc), (m == 4'h9) ? 32'(sbits[8]) : 32'h1);
        check("sdo", 32'(rx), 32'(rdata[7:0]));
      end
      if (m == 4'hB) begin
        get_word(got);
        check("rsvd_word", 32'(got), 32'h0);
        check("rsvd_oe", 32'({bus_oe, sout_oe, rx_en, lanes}), 32'h0);
      end
      word_ready <= 1'b1;
    end
    // Pixel stream fills the FIFO while the user side stalls
    apply_reset(4'hD, 1'b0);
    d = 24'($urandom);
    u_host.set_bus(d);
    word_ready <= 1'b0;
    pvalid <= 1'b1; // Host qualifies every pixel
    pix_run <= 1'b1;
    repeat (200) @(posedge clk);
    check("full", 32'(acc_ready), 32'h0);
    pix_run <= 1'b0;
    pvalid <= 1'b0;
    repeat (20) @(posedge clk);
    word_ready <= 1'b1;
    cnt = 0;
    repeat (30) begin
      get_word(got);
      if (got) begin
        cnt++;
        check("pix", 32'(word_data), 32'(d));
      end
    end
    check("drained", 32'(cnt >= 16 && cnt <= 18), 32'h1);
    check("empty", 32'(acc_ready), 32'h1);
    // Straps moved after latching leave the mode alone
    strap <= 4'h2;
    repeat (10) @(posedge clk);
    check("hold", 32'(mode), 32'hD);
    print_verdict();
  end
endmodule
`default_nettype wire
